/* hdl/mpt_pkg.sv */
package mpt_pkg;

	// Data and address widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;

	// Register indices
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_PERIOD = 4'h1;
	localparam logic [3:0] OFS_DUTY = 4'h2;
	localparam logic [3:0] OFS_PHASE = 4'h3;
	localparam logic [3:0] OFS_CLOCK_CONTROL = 4'h4;
	localparam logic [3:0] OFS_TIMER = 4'h5;
	localparam logic [3:0] OFS_INT_STATUS = 4'h6;
	localparam logic [3:0] OFS_INT_CLEAR = 4'h7;
	localparam logic [3:0] OFS_INT_ENABLE = 4'h8;

	// Control register field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_OVR_BIT = 3;
	localparam int CTRL_OFS_LSB = 4;

	// Clock control field positions
	localparam int CLK_CS_LSB = 0;
	localparam int CLK_PS_LSB = 4;

	// Waveform modes
	localparam logic [1:0] MODE_STANDARD = 2'h0;
	localparam logic [1:0] MODE_SET_ON_MATCH = 2'h1;
	localparam logic [1:0] MODE_TOGGLE = 2'h2;
	localparam logic [1:0] MODE_CENTER = 2'h3;

	// Clock sources
	localparam logic [1:0] CS_SYSTEM = 2'h0;
	localparam logic [1:0] CS_HFINT = 2'h1;
	localparam logic [1:0] CS_LFINT = 2'h2;

	// Offset resync modes
	localparam logic [1:0] OFSM_OFF = 2'h0;

	// Interrupt event bits
	localparam int INT_W = 4;
	localparam int EV_PERIOD = 0;
	localparam int EV_DUTY = 1;
	localparam int EV_PHASE = 2;
	localparam int EV_OFFSET = 3;

	// Reset values
	localparam logic [7:0] CLKCON_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	typedef struct packed {
		logic [1:0] offset_mode;
		logic level_override_bit;
		logic [1:0] mode;
		logic enable;
	} mpt_control_t;

	typedef struct packed {
		logic [2:0] clock_divider_select;
		logic [1:0] clock_source_select;
	} mpt_clock_control_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} mpt_bus_req_t;

endpackage : mpt_pkg

/* hdl/mpt_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none

module mpt_prescaler (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Source tick and divider setting
	input wire logic src_tick,
	input wire logic clear,
	input wire logic [2:0] div_sel,
	// Prescaled tick
	output logic tick
);

	typedef struct packed {
		logic [6:0] cnt;
		logic tick;
	} mpt_pre_state_t;

	mpt_pre_state_t st_reg;
	mpt_pre_state_t st_next;
	logic [6:0] mask;

	always_comb
	begin
		st_next = st_reg;
		mask = 7'(({7'h00, 1'b1} << div_sel) - 8'h01);
		st_next.tick = 1'b0;
		if (clear)
		begin
			st_next.cnt = 7'h00;
		end
		else if (src_tick)
		begin
			if ((st_reg.cnt & mask) == mask)
			begin
				st_next.cnt = 7'h00;
				st_next.tick = 1'b1;
			end
			else
			begin
				st_next.cnt = st_reg.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

endmodule : mpt_prescaler

`default_nettype wire

/* hdl/mpt_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module mpt_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire mpt_pkg::mpt_bus_req_t bus_req,
	output logic [15:0] rdata,
	// Clock source pins
	input wire logic high_freq_internal_osc,
	input wire logic low_freq_internal_osc,
	// Offset match event pin
	input wire logic offset_match_in,
	// Outputs
	output logic pwm_out,
	output logic irq
);

	typedef struct packed {
		logic [2:0] hf_sync;
		logic [2:0] lf_sync;
		logic [2:0] ofs_sync;
		mpt_pkg::mpt_control_t ctrl;
		mpt_pkg::mpt_clock_control_t clkcon;
		logic [15:0] period_count;
		logic [15:0] duty_count;
		logic [15:0] phase_count;
		logic [15:0] pwm_timer_count;
		logic count_down;
		logic ovr_pending;
		logic ofs_pending;
		logic out_level;
		logic [3:0] int_status;
		logic [3:0] int_enable;
		logic [15:0] rdata;
		logic irq;
	} mpt_state_t;

	mpt_state_t st_reg;
	mpt_state_t st_next;
	logic src_tick;
	logic tick;
	logic [3:0] events;
	logic [3:0] clr_mask;
	logic [15:0] up_match;
	logic [15:0] down_match;
	logic phase_hit;
	logic duty_hit;
	logic period_hit;

	function automatic logic reg_write(input mpt_pkg::mpt_bus_req_t req, input logic [3:0] ofs);
		reg_write = req.wr && (req.addr == ofs);
	endfunction : reg_write

	// Clock source choice
	always_comb
	begin
		unique case (st_reg.clkcon.clock_source_select)
			mpt_pkg::CS_SYSTEM: src_tick = 1'b1;
			mpt_pkg::CS_HFINT: src_tick = st_reg.hf_sync[1] && !st_reg.hf_sync[2];
			mpt_pkg::CS_LFINT: src_tick = st_reg.lf_sync[1] && !st_reg.lf_sync[2];
			default: src_tick = 1'b0;
		endcase
	end

	mpt_prescaler u_prescaler (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.src_tick(src_tick),
		.clear(!st_reg.ctrl.enable),
		.div_sel(st_reg.clkcon.clock_divider_select),
		.tick(tick)
	);

	// Match values
	always_comb
	begin
		up_match = st_reg.period_count - st_reg.duty_count;
		down_match = up_match + 16'h0001;
		period_hit = st_reg.pwm_timer_count == st_reg.period_count;
		phase_hit = (st_reg.pwm_timer_count == st_reg.phase_count)
			&& (st_reg.pwm_timer_count <= st_reg.period_count);
		duty_hit = st_reg.pwm_timer_count == st_reg.duty_count;
	end

	always_comb
	begin
		st_next = st_reg;
		events = 4'h0;
		clr_mask = 4'h0;
		// Pin synchronisers
		st_next.hf_sync = {st_reg.hf_sync[1:0], high_freq_internal_osc};
		st_next.lf_sync = {st_reg.lf_sync[1:0], low_freq_internal_osc};
		st_next.ofs_sync = {st_reg.ofs_sync[1:0], offset_match_in};

		// Offset event capture
		if (st_reg.ofs_sync[1] && !st_reg.ofs_sync[2] && (st_reg.ctrl.offset_mode != mpt_pkg::OFSM_OFF)
			&& st_reg.ctrl.enable)
		begin
			st_next.ofs_pending = 1'b1;
			events[mpt_pkg::EV_OFFSET] = 1'b1;
		end

		// Waveform engine
		if (!st_reg.ctrl.enable)
		begin
			st_next.pwm_timer_count = mpt_pkg::COUNT_RESET;
			st_next.out_level = 1'b0;
			st_next.count_down = 1'b0;
			st_next.ofs_pending = 1'b0;
		end
		else if (tick)
		begin
			if (st_reg.ofs_pending)
			begin
				st_next.pwm_timer_count = mpt_pkg::COUNT_RESET;
				st_next.count_down = 1'b0;
				st_next.ofs_pending = 1'b0;
			end
			else if (st_reg.ctrl.mode == mpt_pkg::MODE_CENTER)
			begin
				if (!st_reg.count_down)
				begin
					if (period_hit)
					begin
						st_next.count_down = 1'b1;
						st_next.pwm_timer_count = (st_reg.period_count == 16'h0000) ? 16'h0000
							: st_reg.pwm_timer_count - 16'h0001;
					end
					else
					begin
						st_next.pwm_timer_count = st_reg.pwm_timer_count + 16'h0001;
					end
				end
				else if (st_reg.pwm_timer_count == 16'h0000)
				begin
					st_next.count_down = 1'b0;
					st_next.pwm_timer_count = (st_reg.period_count == 16'h0000) ? 16'h0000 : 16'h0001;
				end
				else
				begin
					st_next.pwm_timer_count = st_reg.pwm_timer_count - 16'h0001;
				end
			end
			else if (period_hit || (st_reg.pwm_timer_count > st_reg.period_count))
			begin
				st_next.pwm_timer_count = mpt_pkg::COUNT_RESET;
			end
			else
			begin
				st_next.pwm_timer_count = st_reg.pwm_timer_count + 16'h0001;
			end

			if (period_hit)
			begin
				events[mpt_pkg::EV_PERIOD] = 1'b1;
			end
			if (phase_hit)
			begin
				events[mpt_pkg::EV_PHASE] = 1'b1;
			end
			if (duty_hit)
			begin
				events[mpt_pkg::EV_DUTY] = 1'b1;
			end

			unique case (st_reg.ctrl.mode)
				mpt_pkg::MODE_STANDARD:
				begin
					if (phase_hit)
					begin
						st_next.out_level = 1'b1;
					end
					if (duty_hit)
					begin
						st_next.out_level = 1'b0;
					end
				end
				mpt_pkg::MODE_SET_ON_MATCH:
				begin
					if (st_reg.ovr_pending)
					begin
						st_next.out_level = st_reg.ctrl.level_override_bit;
					end
					else if (phase_hit)
					begin
						st_next.out_level = 1'b1;
					end
				end
				mpt_pkg::MODE_TOGGLE:
				begin
					if (phase_hit)
					begin
						st_next.out_level = !st_reg.out_level;
					end
				end
				mpt_pkg::MODE_CENTER:
				begin
					if (!st_reg.count_down && (st_reg.pwm_timer_count == up_match))
					begin
						st_next.out_level = 1'b1;
					end
					else if (st_reg.count_down && (st_reg.pwm_timer_count == down_match))
					begin
						st_next.out_level = 1'b0;
					end
				end
			endcase
			st_next.ovr_pending = 1'b0;
		end

		// Register writes
		if (reg_write(bus_req, mpt_pkg::OFS_CONTROL))
		begin
			st_next.ctrl.enable = bus_req.wdata[mpt_pkg::CTRL_EN_BIT];
			st_next.ctrl.mode = bus_req.wdata[mpt_pkg::CTRL_MODE_LSB +: 2];
			st_next.ctrl.level_override_bit = bus_req.wdata[mpt_pkg::CTRL_OVR_BIT];
			st_next.ctrl.offset_mode = bus_req.wdata[mpt_pkg::CTRL_OFS_LSB +: 2];
			if (bus_req.wdata[mpt_pkg::CTRL_MODE_LSB +: 2] == mpt_pkg::MODE_SET_ON_MATCH)
			begin
				st_next.ovr_pending = 1'b1;
			end
			if (!bus_req.wdata[mpt_pkg::CTRL_OVR_BIT] && (st_reg.ctrl.mode == mpt_pkg::MODE_SET_ON_MATCH))
			begin
				st_next.ovr_pending = 1'b1;
			end
		end
		if (reg_write(bus_req, mpt_pkg::OFS_PERIOD))
		begin
			st_next.period_count = bus_req.wdata;
		end
		if (reg_write(bus_req, mpt_pkg::OFS_DUTY))
		begin
			st_next.duty_count = bus_req.wdata;
		end
		if (reg_write(bus_req, mpt_pkg::OFS_PHASE))
		begin
			st_next.phase_count = bus_req.wdata;
		end
		if (reg_write(bus_req, mpt_pkg::OFS_CLOCK_CONTROL))
		begin
			st_next.clkcon.clock_divider_select = bus_req.wdata[mpt_pkg::CLK_PS_LSB +: 3];
			st_next.clkcon.clock_source_select = bus_req.wdata[mpt_pkg::CLK_CS_LSB +: 2];
		end
		if (reg_write(bus_req, mpt_pkg::OFS_INT_ENABLE))
		begin
			st_next.int_enable = bus_req.wdata[3:0];
		end
		if (reg_write(bus_req, mpt_pkg::OFS_INT_CLEAR))
		begin
			clr_mask = bus_req.wdata[3:0];
		end

		// Sticky status, set beats clear
		st_next.int_status = (st_reg.int_status & ~clr_mask) | events;
		st_next.irq = |(st_next.int_status & st_next.int_enable);

		// Read data, one cycle after strobe
		st_next.rdata = 16'h0000;
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				mpt_pkg::OFS_CONTROL: st_next.rdata = {10'h000, st_reg.ctrl};
				mpt_pkg::OFS_PERIOD: st_next.rdata = st_reg.period_count;
				mpt_pkg::OFS_DUTY: st_next.rdata = st_reg.duty_count;
				mpt_pkg::OFS_PHASE: st_next.rdata = st_reg.phase_count;
				mpt_pkg::OFS_CLOCK_CONTROL: st_next.rdata = {9'h000, st_reg.clkcon.clock_divider_select,
					2'h0, st_reg.clkcon.clock_source_select};
				mpt_pkg::OFS_TIMER: st_next.rdata = st_reg.pwm_timer_count;
				mpt_pkg::OFS_INT_STATUS: st_next.rdata = {12'h000, st_reg.int_status};
				mpt_pkg::OFS_INT_ENABLE: st_next.rdata = {12'h000, st_reg.int_enable};
				default: st_next.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			st_reg <= '0;
			st_reg.clkcon.clock_divider_select <= mpt_pkg::CLKCON_RESET[mpt_pkg::CLK_PS_LSB +: 3];
			st_reg.clkcon.clock_source_select <= mpt_pkg::CLKCON_RESET[mpt_pkg::CLK_CS_LSB +: 2];
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
	assign pwm_out = st_reg.out_level;
	assign irq = st_reg.irq;

endmodule : mpt_timer

`default_nettype wire

/* testbench/mpt_timer_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module mpt_timer_assertions (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire mpt_pkg::mpt_bus_req_t bus_req,
	input wire logic [15:0] rdata,
	// Outputs
	input wire logic pwm_out,
	input wire logic irq
);
	logic [7:0] clk_reg;

	// Last clock control write
	always_ff @(posedge clk_sys)
		if (!rst_b)
			clk_reg <= 8'h00;
		else if (bus_req.wr && bus_req.addr == 4'h4)
			clk_reg <= bus_req.wdata[7:0];

	default clocking main_cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence read_of(logic [3:0] a);
		bus_req.rd && bus_req.addr == a;
	endsequence

	sequence write_of(logic [3:0] a);
		bus_req.wr && bus_req.addr == a;
	endsequence

	reset_quiet_a: assert property ($rose(rst_b) |-> !pwm_out && !irq && rdata == 16'h0000)
		else $error("outputs busy after reset");
	clk_value_a: assert property (read_of(4'h4) |=> rdata == {9'h000, clk_reg[6:4], 2'b00, clk_reg[1:0]})
		else $error("clock control readback wrong");
	disable_out_a: assert property (write_of(4'h0) && !bus_req.wdata[0] |-> ##3 !pwm_out [*6])
		else $error("output active while disabled");
	override_set_a: assert property (write_of(4'h0) && bus_req.wdata[3:0] == 4'hb && clk_reg == 8'h00 |-> ##[1:5] pwm_out)
		else $error("override set not applied");
	irq_mask_a: assert property (write_of(4'h8) && bus_req.wdata[3:0] == 4'h0 |-> ##3 !irq [*4])
		else $error("irq high while masked");
	rd_idle_a: assert property (!bus_req.rd |=> rdata == 16'h0000)
		else $error("read data outside read slot");
	unmapped_a: assert property (bus_req.rd && (bus_req.addr == 4'h7 || bus_req.addr > 4'h8) |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	status_bits_a: assert property (read_of(4'h6) |=> rdata[15:4] == 12'h000)
		else $error("status spare bits set");
endmodule : mpt_timer_assertions

bind mpt_timer mpt_timer_assertions mpt_timer_assertions_inst (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
	.rdata(rdata), .pwm_out(pwm_out), .irq(irq));

`default_nettype wire

/* testbench/mpt_pwm_load.sv */
`timescale 1ns/100ps
`default_nettype none

module mpt_pwm_load (
	// Clock
	input wire logic clk_sys,
	// Observed line
	input wire logic pwm_out,
	// Measured lengths in cycles
	output var int period_len,
	output var int high_len
);
	logic prev = 1'b0;
	int since = 0;

	always @(posedge clk_sys)
	begin
		prev <= pwm_out;
		since <= (pwm_out && !prev) ? 1 : since + 1;
		if (pwm_out && !prev)
			period_len <= since;
		if (!pwm_out && prev)
			high_len <= since;
	end
endmodule : mpt_pwm_load

`default_nettype wire

/* testbench/multi_mode_pwm_timer_test.sv */
`timescale 1ns/100ps
`default_nettype none

module multi_mode_pwm_timer_test;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] osc_div = 2'h0;
	logic ofs_in = 1'b0;
	mpt_pkg::mpt_bus_req_t req = '0;
	logic [15:0] rdata;
	logic pwm_out;
	logic irq;
	logic [15:0] pr = 16'h0009;
	logic [15:0] dc;
	logic [15:0] ph;
	logic [15:0] rv;
	int pl;
	int hl;
	int seed = 32'hca959704;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;

	always #25 clk_sys = !clk_sys;
	always @(posedge clk_sys) osc_div <= osc_div + 2'h1;

	mpt_timer mpt_timer_inst (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(req), .rdata(rdata),
		.high_freq_internal_osc(osc_div[0]), .low_freq_internal_osc(osc_div[1]), .offset_match_in(ofs_in),
		.pwm_out(pwm_out), .irq(irq));
	mpt_pwm_load mpt_pwm_load_inst (.clk_sys(clk_sys), .pwm_out(pwm_out), .period_len(pl), .high_len(hl));

	task automatic complete_run();
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			miscompares++;
			complete_run();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 rv = rdata;
	endtask : rd

	// Tick-level reference: returns period or high length in ticks
	function automatic int model(int md, int p, int d, int h, bit hi);
		int t = 0;
		int up = 1;
		int o = 0;
		int po;
		int last = 0;
		int per = 0;
		int c = 0;
		int hm = 0;
		for (int k = 0; k < 600; k++)
		begin
			po = o;
			case (md)
				0: o = (t == d) ? 0 : (t == h) ? 1 : o;
				2: o = (t == h) ? !o : o;
				3: o = (up && t == p - d) ? 1 : (!up && t == p - d + 1) ? 0 : o;
			endcase
			if (md == 3)
			begin
				up = (t == p) ? 0 : (t == 0) ? 1 : up;
				t = up ? t + 1 : t - 1;
			end
			else
				t = (t >= p) ? 0 : t + 1;
			if (o && !po)
			begin
				per = k - last;
				last = k;
				c = 0;
			end
			c = o ? c + 1 : c;
			hm = (!o && po) ? c : hm;
		end
		return hi ? hm : per;
	endfunction : model

	task automatic run(input int md, input int ps, input int cs);
		int s;
		int p;
		int h;
		s = (1 << ps) * (cs == 1 ? 2 : (cs == 2 ? 4 : 1));
		p = model(md, pr, dc, ph, 1'b0) * s;
		h = model(md, pr, dc, ph, 1'b1) * s;
		wr(4'h0, 16'h0000);
		wr(4'h4, 16'((ps << 4) | cs));
		wr(4'h1, pr);
		wr(4'h2, dc);
		wr(4'h3, ph);
		wr(4'h0, 16'(9 | (md << 1)));
		repeat (3 * p + 20) @(posedge clk_sys);
		chk("period", pl, p);
		chk("high", hl, h);
	endtask : run

	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(4'h4);
		chk("clock control", rv, 16'h0000);
		wr(4'h5, 16'h0005);
		rd(4'h5);
		chk("timer idle", rv, 16'h0000);
		rd(4'hf);
		chk("unmapped", rv, 16'h0000);
		wr(4'h4, 16'h0003);
		wr(4'h0, 16'h0001);
		repeat (10) @(posedge clk_sys);
		rd(4'h5);
		chk("reserved source", rv, 16'h0000);
		wr(4'h4, 16'h0000);
		wr(4'h1, 16'h00ff);
		wr(4'h0, 16'h0011);
		repeat (40) @(posedge clk_sys);
		ofs_in <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ofs_in <= 1'b0;
		rd(4'h5);
		chk("offset resync", rv, 16'h0001);
		rd(4'h6);
		chk("offset event", rv & 16'h0008, 16'h0008);
		ph = 16'($unsigned($random(seed)) % 4);
		dc = 16'(4 + $unsigned($random(seed)) % 5);
		for (int m = 0; m < 4; m++)
			if (m != 1)
				run(m, 0, 0);
		for (int ps = 1; ps < 8; ps++)
			run(0, ps, 0);
		for (int cs = 1; cs < 3; cs++)
			run(0, 0, cs);
		wr(4'h4, 16'h0000);
		wr(4'h3, 16'h000c);
		wr(4'h0, 16'h000b);
		repeat (6) @(posedge clk_sys);
		chk("override set", pwm_out, 1'b1);
		wr(4'h0, 16'h0003);
		repeat (30) @(posedge clk_sys);
		chk("above period", pwm_out, 1'b0);
		wr(4'h3, 16'h0003);
		repeat (15) @(posedge clk_sys);
		chk("phase set", pwm_out, 1'b1);
		wr(4'h8, 16'h0001);
		repeat (30) @(posedge clk_sys);
		chk("sticky", pwm_out, 1'b1);
		chk("irq raised", irq, 1'b1);
		rd(4'h6);
		chk("status", rv, 16'h000f);
		wr(4'h8, 16'h0000);
		repeat (4) @(posedge clk_sys);
		chk("irq masked", irq, 1'b0);
		wr(4'h0, 16'h0000);
		repeat (4) @(posedge clk_sys);
		chk("disabled", pwm_out, 1'b0);
		wr(4'h7, 16'h000f);
		wr(4'h8, 16'h000f);
		rd(4'h6);
		chk("cleared", rv, 16'h0000);
		rd(4'h5);
		chk("timer zero", rv, 16'h0000);
		repeat (3) @(posedge clk_sys);
		chk("irq low", irq, 1'b0);
		complete_run();
	end
endmodule : multi_mode_pwm_timer_test

`default_nettype wire
